// ---- shared/tws_pkg.sv ----
// Purpose: Shared constants and types for the two-wire slave controller
// Assumes: 250 MHz ref_clk, byte-wide registers on a 32-bit Avalon-MM bus
// Notes: Register offsets are word indices; byte address is index times four
package tws_pkg;
   // Word indices of the registers
   localparam logic [5:0] IDX_OWN_ADDR = 6'h2a;
   localparam logic [5:0] IDX_STATUS_A = 6'h2b;
   localparam logic [5:0] IDX_CTRL_B = 6'h2c;
   localparam logic [5:0] IDX_CTRL_A = 6'h2d;
   localparam logic [5:0] IDX_DATA = 6'h2e;
   // slave_control_a fields
   localparam int CA_SDA_HOLD = 7;
   localparam int CA_DIE = 5;
   localparam int CA_ASIE = 4;
   localparam int CA_EN = 3;
   localparam int CA_SIE = 2;
   localparam int CA_PME = 1;
   localparam int CA_SME = 0;
   localparam logic [7:0] CA_WMASK = 8'hbf;
   localparam logic [7:0] CA_RESET = 8'h00;
   // slave_control_b fields
   localparam int CB_AA = 2;
   localparam int CB_CMD_HI = 1;
   localparam int CB_CMD_LO = 0;
   // slave_status_a fields
   localparam int SA_DF = 7;
   localparam int SA_ASF = 6;
   localparam int SA_CH = 5;
   localparam int SA_RA = 4;
   localparam int SA_COLL = 3;
   localparam int SA_BE = 2;
   localparam int SA_DIR = 1;
   localparam int SA_AS = 0;
   localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Timing
   localparam int CLK_MHZ = 250;
   localparam int SDA_HOLD_NS = 50;
   localparam int SDA_HOLD_CYC_I = (SDA_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] SDA_HOLD_CYC = 4'(SDA_HOLD_CYC_I);

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_HOLD, ST_ACK, ST_RX, ST_RX_HOLD,
      ST_TX_HOLD, ST_TX, ST_TX_ACK, ST_WAIT_START
   } tws_state_e;

   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } tws_ev_t;

   typedef struct packed {
      tws_state_e st;
      logic [7:0] ca;
      logic aa;
      logic [7:0] own;
      logic [7:0] data;
      logic [7:0] shift;
      logic [3:0] cnt;
      logic df;
      logic asf;
      logic ra;
      logic coll;
      logic be;
      logic dir;
      logic as_addr;
      logic nack;
      logic done;
      logic [3:0] hold_cnt;
      logic sda_oe;
      logic scl_oe;
      logic irq;
      logic wreq;
      logic [7:0] rdata;
   } tws_st_t;
endpackage

// ---- hdl/tws_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pin idles high, as an open-drain bus line does
// Notes: Level changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module tws_sync (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pin,
   output var logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } tws_sync_st_t;
   tws_sync_st_t r, n;

   always_comb begin
      n = r;
      n.s1 = pin;
      n.s2 = r.s1;
      n.s3 = r.s2;
      if (r.s2 == r.s3) begin
         n.lvl = r.s3;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= 4'hf;
      end else begin
         r <= n;
      end
   end

   assign level = r.lvl;
endmodule
`default_nettype wire

// ---- hdl/tws_cond_det.sv ----
// Purpose: Finds START, STOP and SCL edges on the filtered bus lines
// Assumes: Inputs are already synchronised to ref_clk
// Notes: Events are one-cycle pulses, one cycle after the line change
`timescale 1ns/1ps
`default_nettype none
module tws_cond_det (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   output tws_pkg::tws_ev_t ev
);
   import tws_pkg::*;
   typedef struct packed {
      logic scl_d;
      logic sda_d;
      tws_ev_t ev;
   } tws_det_st_t;
   tws_det_st_t r, n;

   always_comb begin
      n = r;
      n.scl_d = scl;
      n.sda_d = sda;
      n.ev.start = scl && r.scl_d && r.sda_d && !sda;
      n.ev.stop = scl && r.scl_d && !r.sda_d && sda;
      n.ev.rise = scl && !r.scl_d;
      n.ev.fall = !scl && r.scl_d;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= 6'h30;
      end else begin
         r <= n;
      end
   end

   assign ev = r.ev;
endmodule
`default_nettype wire

// ---- hdl/tws_slave.sv ----
// Purpose: Byte-oriented two-wire bus slave with Avalon-MM register access
// Assumes: External master drives SCL; software services held clocks
// Notes: Open-drain lines as in, out and enable; enable high pulls low
`timescale 1ns/1ps
`default_nettype none
module tws_slave (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic irq_req
);
   import tws_pkg::*;

   tws_st_t r, n;
   logic scl_lvl;
   logic sda_lvl;
   tws_ev_t ev;

   tws_sync u_scl_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin(scl_in),
      .level(scl_lvl)
   );

   tws_sync u_sda_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin(sda_in),
      .level(sda_lvl)
   );

   tws_cond_det u_det (
      .ref_clk(ref_clk),
      .rst(rst),
      .scl(scl_lvl),
      .sda(sda_lvl),
      .ev(ev)
   );

   logic acc;
   logic wr;
   logic rd;
   logic [5:0] idx;
   logic [7:0] wd;
   logic cmd1x;
   logic cmd10;
   logic data_acc;
   logic trig_addr;
   logic trig_rx;
   logic en;
   logic want;
   logic matched;
   logic [7:0] status;

   always_comb begin
      n = r;
      acc = (avs_read || avs_write) && r.wreq;
      wr = acc && avs_write;
      rd = acc && avs_read;
      idx = avs_address[7:2];
      wd = avs_writedata[7:0];
      en = r.ca[CA_EN];
      status = 8'h00;
      status[SA_DF] = r.df;
      status[SA_ASF] = r.asf;
      status[SA_CH] = r.df || r.asf;
      status[SA_RA] = r.ra;
      status[SA_COLL] = r.coll;
      status[SA_BE] = r.be;
      status[SA_DIR] = r.dir;
      status[SA_AS] = r.as_addr;
      cmd1x = 1'b0;
      cmd10 = 1'b0;
      data_acc = 1'b0;
      trig_addr = 1'b0;
      trig_rx = 1'b0;

      // One access per request: answer one cycle after it is seen
      n.wreq = !acc;
      if (rd) begin
         if (idx == IDX_CTRL_A) begin
            n.rdata = r.ca;
         end else if (idx == IDX_CTRL_B) begin
            n.rdata = {5'h00, r.aa, 2'h0};
         end else if (idx == IDX_STATUS_A) begin
            n.rdata = status;
         end else if (idx == IDX_OWN_ADDR) begin
            n.rdata = r.own;
         end else if (idx == IDX_DATA) begin
            n.rdata = r.data;
            data_acc = 1'b1;
         end else begin
            n.rdata = 8'h00;
         end
      end

      if (wr) begin
         if (idx == IDX_CTRL_A) begin
            n.ca = wd & CA_WMASK;
         end else if (idx == IDX_CTRL_B) begin
            n.aa = wd[CB_AA];
            cmd1x = wd[CB_CMD_HI];
            cmd10 = wd[CB_CMD_HI] && !wd[CB_CMD_LO];
         end else if (idx == IDX_STATUS_A) begin
            // Write one to clear; clearing the address flag can trigger the ack
            trig_addr = wd[SA_ASF] && r.asf && r.st == ST_ADDR_HOLD;
            trig_rx = wd[SA_DF] && r.df && r.st == ST_RX_HOLD;
            n.df = r.df && !wd[SA_DF];
            n.asf = r.asf && !wd[SA_ASF];
            n.coll = r.coll && !wd[SA_COLL];
            n.be = r.be && !wd[SA_BE];
         end else if (idx == IDX_OWN_ADDR) begin
            n.own = wd;
         end else if (idx == IDX_DATA) begin
            // Data only moves while the clock is held, never mid-byte
            if (r.df || r.asf) begin
               n.data = wd;
            end
            data_acc = 1'b1;
         end
      end

      if (data_acc) begin
         n.df = 1'b0;
         n.asf = 1'b0;
      end
      if (cmd1x) begin
         n.df = 1'b0;
         n.asf = 1'b0;
      end

      // Software actions on a held byte
      case (r.st)
         ST_ADDR_HOLD: begin
            if (cmd1x || trig_addr) begin
               if (r.dir && cmd10) begin
                  n.st = ST_WAIT_START;
               end else begin
                  n.st = ST_ACK;
                  n.nack = n.aa;
                  n.done = cmd10;
               end
            end
         end
         ST_RX_HOLD: begin
            if (cmd1x || trig_rx || (rd && idx == IDX_DATA && r.ca[CA_SME])) begin
               n.st = ST_ACK;
               n.nack = n.aa;
               n.done = cmd10;
            end
         end
         ST_TX_HOLD: begin
            if (cmd10) begin
               n.st = ST_WAIT_START;
            end else if ((wr && idx == IDX_DATA) || cmd1x) begin
               n.st = ST_TX;
               n.shift = n.data;
               n.cnt = 4'h0;
            end
         end
         default: begin
         end
      endcase

      // Address compare, any address with CA_PME, else own address or general call
      matched = r.ca[CA_PME]
         || (r.shift[7:1] == r.own[7:1])
         || (r.own[0] && r.shift[7:1] == 7'h00);

      // Bus events, taken after software so that a set wins over a clear
      if (!en) begin
         n.st = ST_IDLE;
         n.df = 1'b0;
         n.asf = 1'b0;
      end else if (ev.start) begin
         if ((r.st == ST_ADDR || r.st == ST_RX || r.st == ST_TX) && r.cnt != 4'h0) begin
            n.be = 1'b1;
         end
         n.coll = 1'b0;
         n.st = ST_ADDR;
         n.cnt = 4'h0;
      end else if (ev.stop) begin
         if (r.st == ST_ADDR || ((r.st == ST_RX || r.st == ST_TX) && r.cnt != 4'h0)) begin
            n.be = 1'b1;
         end
         if (r.ca[CA_SIE]) begin
            n.asf = 1'b1;
            n.as_addr = 1'b0;
         end
         n.st = ST_IDLE;
      end else begin
         case (r.st)
            ST_ADDR, ST_RX: begin
               if (ev.rise) begin
                  n.shift = {r.shift[6:0], sda_lvl};
                  n.cnt = r.cnt + 4'h1;
               end else if (ev.fall && r.cnt == BYTE_BITS) begin
                  if (r.st == ST_RX) begin
                     n.df = 1'b1;
                     n.data = r.shift;
                     n.st = ST_RX_HOLD;
                  end else if (matched) begin
                     n.asf = 1'b1;
                     n.as_addr = 1'b1;
                     n.dir = r.shift[0];
                     n.st = ST_ADDR_HOLD;
                  end else begin
                     n.st = ST_WAIT_START;
                  end
               end
            end
            ST_ACK: begin
               if (ev.rise && r.nack && !sda_lvl) begin
                  n.coll = 1'b1;
                  n.st = ST_WAIT_START;
               end else if (ev.fall) begin
                  if (r.nack || r.done) begin
                     n.st = ST_WAIT_START;
                  end else if (r.dir) begin
                     n.df = 1'b1;
                     n.st = ST_TX_HOLD;
                  end else begin
                     n.st = ST_RX;
                     n.cnt = 4'h0;
                  end
               end
            end
            ST_TX: begin
               if (ev.rise && r.shift[7] && !sda_lvl) begin
                  n.coll = 1'b1;
                  n.st = ST_WAIT_START;
               end else if (ev.fall) begin
                  n.shift = {r.shift[6:0], 1'b0};
                  n.cnt = r.cnt + 4'h1;
                  if (r.cnt + 4'h1 == BYTE_BITS) begin
                     n.st = ST_TX_ACK;
                  end
               end
            end
            ST_TX_ACK: begin
               if (ev.rise) begin
                  n.ra = sda_lvl;
               end else if (ev.fall) begin
                  if (r.ra) begin
                     n.st = ST_WAIT_START;
                  end else begin
                     n.df = 1'b1;
                     n.st = ST_TX_HOLD;
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // Pull SDA low only for an ACK or a zero data bit
      want = ((n.st == ST_ACK && !n.nack) || (n.st == ST_TX && !n.shift[7])) && !n.coll;
      if (r.ca[CA_SDA_HOLD] && ev.fall) begin
         n.hold_cnt = SDA_HOLD_CYC;
      end else if (r.hold_cnt != 4'h0) begin
         n.hold_cnt = r.hold_cnt - 4'h1;
      end
      if (n.hold_cnt == 4'h0 || !want) begin
         n.sda_oe = want;
      end
      // Outputs follow the new enable, so a disable write frees the bus at once
      if (!n.ca[CA_EN]) begin
         n.sda_oe = 1'b0;
      end
      // Holding starts only after a flag is set, at an SCL fall or at a STOP with CA_SIE
      n.scl_oe = n.ca[CA_EN] && (n.df || n.asf);
      n.irq = (n.ca[CA_DIE] && n.df) || (n.ca[CA_ASIE] && n.asf);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.ca <= CA_RESET;
         r.own <= OWN_ADDR_RESET;
         r.wreq <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign avs_readdata = {24'h000000, r.rdata};
   assign avs_waitrequest = r.wreq;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = r.scl_oe;
   assign sda_oe = r.sda_oe;
   assign irq_req = r.irq;
endmodule
`default_nettype wire

// ---- test/tws_slave_asserts.sv ----
// Purpose: Port-level checks on the two-wire slave
// Assumes: One clock domain, synchronous active-high reset
// Notes: Shadows of control A bits come from taken bus writes
`timescale 1ns/1ps
`default_nettype none
module tws_slave_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic irq_req
);
   import tws_pkg::*;
   logic req;
   logic tk;
   logic en_r;
   logic ie_r;
   assign req = avs_read | avs_write;
   assign tk = req & avs_waitrequest;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         en_r <= 1'b0;
         ie_r <= 1'b0;
      end else if (tk && avs_write && avs_address[7:2] == IDX_CTRL_A) begin
         en_r <= avs_writedata[CA_EN];
         ie_r <= avs_writedata[CA_DIE] | avs_writedata[CA_ASIE];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_wait_answer: assert property (tk |=> !avs_waitrequest) else $error("request not answered");
   a_ctrl_a_read: assert property (tk && avs_read && avs_address[7:2] == IDX_CTRL_A
      |=> avs_readdata[6] == 1'b0 && avs_readdata[31:8] == 24'h0) else $error("control A reserved bit set");
   a_ctrl_b_read: assert property (tk && avs_read && avs_address[7:2] == IDX_CTRL_B
      |=> avs_readdata[7:3] == 5'h0 && avs_readdata[1:0] == 2'h0) else $error("control B reads nonzero");
   a_cmd_release: assert property (tk && avs_write && avs_address[7:2] == IDX_CTRL_B && avs_writedata[CB_CMD_HI]
      |-> ##[1:3] !scl_oe) else $error("command left clock held");
   a_data_release: assert property (tk && avs_address[7:2] == IDX_DATA |-> ##[1:3] !scl_oe)
      else $error("data access left clock held");
   a_hold_stays: assert property (scl_oe && !req && !$past(req) && !$past(req, 2) |=> scl_oe)
      else $error("clock released without software");
   a_off_quiet: assert property (!en_r |-> !sda_oe && !scl_oe) else $error("disabled slave drives bus");
   a_irq_masked: assert property (!ie_r && !$past(ie_r) |-> !irq_req) else $error("masked interrupt raised");
endmodule
bind tws_slave tws_slave_chk chk (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq_req(irq_req));
`default_nettype wire

// ---- test/tws_mst.sv ----
// Purpose: Behavioural two-wire bus master
// Assumes: Open-drain lines resolved by the bench, 160 ns bit time
// Notes: Clock stands high between frames; waits out stretching
`timescale 1ns/1ps
`default_nettype none
module tws_mst (
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // Release and wait, since the slave may stretch the low phase
   task automatic rise();
      scl_oe = 1'b0;
      wait (scl === 1'b1);
   endtask
   task automatic wbit(input logic b);
      sda_oe = !b;
      #40 rise();
      #80 scl_oe = 1'b1;
      #40;
   endtask
   task automatic rbit(output logic b);
      sda_oe = 1'b0;
      #40 rise();
      #40 b = sda;
      #40 scl_oe = 1'b1;
      #40;
   endtask
   task automatic start();
      sda_oe = 1'b0;
      #40 rise();
      #40 sda_oe = 1'b1;
      #40 scl_oe = 1'b1;
      #40;
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      #40 rise();
      #40 sda_oe = 1'b0;
      #80;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic n);
      for (int i = 7; i >= 0; i--) wbit(d[i]);
      rbit(n);
   endtask
   task automatic rbyte(output logic [7:0] d, input logic n);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         rbit(b);
         d[i] = b;
      end
      wbit(n);
   endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the two-wire slave
// Assumes: Software side over Avalon-MM, master model on the bus
// Notes: Random bytes from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tws_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe, irq_req, m_scl_oe, m_sda_oe, nk;
   wire scl_w = !(scl_oe | m_scl_oe);
   wire sda_w = !(sda_oe | m_sda_oe);
   int errors = 0;
   int n_compared = 0;
   logic [31:0] lf = 32'hc75b;
   logic [7:0] q, mq, a7, d1, d2;
   always #2 ref_clk = ~ref_clk;
   tws_slave uut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq_req(irq_req));
   tws_mst mst (.scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   function automatic logic [7:0] rnd();
      for (int i = 0; i < 8; i++) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[7:0];
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Request held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [5:0] i, input logic [7:0] d);
      // Align to a rising edge; callers may return from the link model mid-cycle
      @(posedge ref_clk);
      avs_address <= {i, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_read <= !w;
      avs_write <= w;
      @(posedge ref_clk);
      for (int n = 0; n < 50 && avs_waitrequest !== 1'b0; n++) @(posedge ref_clk);
      if (avs_waitrequest !== 1'b0) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
      end
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      acc(1'b1, i, d);
   endtask
   task automatic rd(input logic [5:0] i, input logic [7:0] m, input logic [7:0] e);
      acc(1'b0, i, 8'h00);
      chk(q & m, e);
   endtask
   task automatic wh();
      for (int n = 0; n < 5000 && scl_oe !== 1'b1; n++) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic tally_and_finish();
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (8) @(posedge ref_clk);
      for (int k = 0; k < 6; k++) rd(k == 5 ? 6'h10 : IDX_OWN_ADDR + 6'(k), 8'hff, 8'h00);
      wr(IDX_CTRL_A, 8'hff);
      rd(IDX_CTRL_A, 8'hff, 8'hbf);
      wr(IDX_CTRL_B, 8'hfc);
      rd(IDX_CTRL_B, 8'hff, 8'h04);
      a7 = rnd() | 8'h10;
      d1 = rnd();
      d2 = rnd();
      wr(IDX_OWN_ADDR, {a7[6:0], 1'b1});
      rd(IDX_OWN_ADDR, 8'hff, {a7[6:0], 1'b1});
      wr(IDX_CTRL_A, 8'h39);
      wr(IDX_CTRL_B, 8'h00);
      // Master write, smart mode; second byte refused
      fork
         begin
            mst.start();
            mst.wbyte({a7[6:0], 1'b0}, nk);
            chk(8'(nk), 8'h00);
            mst.wbyte(d1, nk);
            chk(8'(nk), 8'h00);
            mst.wbyte(d2, nk);
            chk(8'(nk), 8'h01);
            mst.stop();
         end
         begin
            wh();
            chk(8'(irq_req), 8'h01);
            rd(IDX_STATUS_A, 8'hef, 8'h61);
            wr(IDX_CTRL_B, 8'h03);
            wh();
            rd(IDX_STATUS_A, 8'hef, 8'ha1);
            rd(IDX_DATA, 8'hff, d1);
            wr(IDX_CTRL_B, 8'h04);
            wh();
            rd(IDX_DATA, 8'hff, d2);
         end
      join
      rd(IDX_STATUS_A, 8'h40, 8'h00);
      wr(IDX_CTRL_B, 8'h00);
      mst.start();
      mst.wbyte({a7[6:0] ^ 7'h01, 1'b0}, nk);
      chk(8'(nk), 8'h01);
      mst.stop();
      wr(IDX_CTRL_A, 8'h3b);
      fork
         begin
            mst.start();
            mst.wbyte({a7[6:0] ^ 7'h01, 1'b0}, nk);
            chk(8'(nk), 8'h00);
            mst.stop();
         end
         begin
            wh();
            wr(IDX_CTRL_B, 8'h02);
         end
      join
      // Master read of two bytes, ended by the master's refusal
      wr(IDX_CTRL_A, 8'h38);
      fork
         begin
            mst.start();
            mst.wbyte({a7[6:0], 1'b1}, nk);
            chk(8'(nk), 8'h00);
            mst.rbyte(mq, 1'b0);
            chk(mq, d1);
            mst.rbyte(mq, 1'b1);
            chk(mq, d2);
            mst.stop();
         end
         begin
            wh();
            rd(IDX_STATUS_A, 8'hef, 8'h63);
            wr(IDX_CTRL_B, 8'h03);
            wh();
            rd(IDX_STATUS_A, 8'hc0, 8'h80);
            wr(IDX_DATA, d1);
            wh();
            rd(IDX_STATUS_A, 8'h90, 8'h80);
            wr(IDX_DATA, d2);
         end
      join
      rd(IDX_STATUS_A, 8'hd0, 8'h10);
      wr(IDX_CTRL_A, 8'h3c);
      mst.start();
      mst.stop();
      repeat (20) @(posedge ref_clk);
      rd(IDX_STATUS_A, 8'h45, 8'h44);
      wr(IDX_STATUS_A, 8'h44);
      rd(IDX_STATUS_A, 8'h64, 8'h00);
      // Disabled slave must ignore its own address
      wr(IDX_CTRL_A, 8'h30);
      mst.start();
      mst.wbyte({a7[6:0], 1'b0}, nk);
      chk(8'(nk), 8'h01);
      mst.stop();
      tally_and_finish();
   end
endmodule
`default_nettype wire
